/* File: hw/windowed_watchdog_timer.sv */
// windowed watchdog timer: 12-bit down counter on slow clock / 128,
// write-once mode register, key-protected restart, fault request out
// assumes: SLCK_I is an asynchronous slow clock pin, DBG_I and IDLE_I come
// from logic on CLK_I, the reset controller answers FAULT_O by pulsing RST_I
//
// Notes on behaviour
// - 12-bit down counter loaded from load value
// - counter decrements on slow clock / 128
// - after reset load 0xFFF, running, reset enabled
// - mode register takes only first write
// - mode write reloads counter and restarts
// - good restart reloads counter, clears prescaler
// - restart write needs key 0xA5, else ignored
// - underflow sets flag, faults if enabled
// - restart above delta flags error, faults if enabled
// - delta at or above load allows any restart
// - mode register resets to 0x3FFF_2FFF
// - flags interrupt only with fault interrupt enable
// - status read or reset clears flags, fault
// - select bit picks processor or full reset
// - debug or idle halt bits stop counter
// - disable bit stops the counter, late restarts still flag
// - watchdog reset clears watchdog and its flags
// - bit 0 underflow, bit 1 error since read
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int PRESC_DIV = SLOW_DIV
)
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire logic SLCK_I,
    input wire logic DBG_I,
    input wire logic IDLE_I,
    output logic IRQ_O,
    output logic FAULT_O,
    output logic PROC_RESET_REQ_O,
    output logic FULL_RESET_REQ_O
);
    localparam int PRESC_W = $clog2(PRESC_DIV);
    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESC_DIV - 1);
    localparam logic [PRESC_W-1:0] PRESC_ZERO = '0;

    generate
        if (PRESC_DIV < 2 || (PRESC_DIV & (PRESC_DIV - 1)) != 0)
        begin : g_bad_div
            $error("PRESC_DIV must be a power of two of at least 2");
        end
    endgenerate

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    mode_t mode_q;
    logic mode_locked_q;
    logic [CNT_W-1:0] cnt_q;
    logic [PRESC_W-1:0] presc_q;
    logic slck_meta_q;
    logic slck_sync_q;
    logic slck_prev_q;
    flags_t flags_q;
    logic [FLAG_W-1:0] irq_en_q;
    logic fault_q;
    logic [31:0] rdata_q;

    logic restart_wr;
    logic key_ok;
    logic restart_req;
    logic restart_ok;
    logic restart_err;
    logic mode_wr_ok;
    logic slow_edge;
    logic tick;
    logic halted;
    logic tick_run;
    logic underflow;
    logic flags_rd;
    logic irq_clr_wr;
    flags_t flags_set;
    flags_t flags_d;
    logic fault_d;

    // bus decode
    assign restart_wr = WR_I && hit(ADDR_I, OFF_RESTART);
    assign key_ok = (WDATA_I[KEY_LSB +: $bits(RESTART_KEY)] == RESTART_KEY);
    assign restart_req = restart_wr && key_ok && WDATA_I[RESTART_BIT];
    // counter never exceeds the load value, so delta >= load never errors
    assign restart_ok = restart_req && (cnt_q <= mode_q.restart_window_delta);
    assign restart_err = restart_req && (cnt_q > mode_q.restart_window_delta);
    assign mode_wr_ok = WR_I && hit(ADDR_I, OFF_MODE) && !mode_locked_q;
    assign flags_rd = RD_I && hit(ADDR_I, OFF_FLAGS);
    assign irq_clr_wr = WR_I && hit(ADDR_I, OFF_IRQ_CLEAR);

    // slow clock pin: two flops, then edge detect on the clean copy
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            // held high: a pin already high at release must not look like an edge
            slck_meta_q <= 1'b1;
            slck_sync_q <= 1'b1;
            slck_prev_q <= 1'b1;
        end
        else
        begin
            slck_meta_q <= SLCK_I;
            slck_sync_q <= slck_meta_q;
            slck_prev_q <= slck_sync_q;
        end
    end

    assign slow_edge = slck_sync_q && !slck_prev_q;
    assign tick = slow_edge && (presc_q == PRESC_LAST);

    // prescaler keeps running through halts so a resume is not early
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            presc_q <= PRESC_ZERO;
        end
        else if (mode_wr_ok || restart_ok)
        begin
            presc_q <= PRESC_ZERO;
        end
        else if (slow_edge)
        begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // mode register, write-once until the next reset
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            mode_q <= mode_t'(MODE_RESET);
            mode_locked_q <= 1'b0;
        end
        else if (mode_wr_ok)
        begin
            mode_q <= mode_t'({2'h0, WDATA_I[29:0]});
            mode_locked_q <= 1'b1;
        end
    end

    assign halted = mode_q.timer_disable
        || (DBG_I && mode_q.debug_halt_select)
        || (IDLE_I && mode_q.idle_halt_select);
    assign tick_run = tick && !halted;
    assign underflow = tick_run && (cnt_q == '0);

    // down counter
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            cnt_q <= CNT_MAX;
        end
        else if (mode_wr_ok)
        begin
            cnt_q <= WDATA_I[CNT_W-1:0];
        end
        else if (restart_ok)
        begin
            cnt_q <= mode_q.counter_load_value;
        end
        else if (tick_run)
        begin
            if (cnt_q == '0)
            begin
                cnt_q <= mode_q.counter_load_value;
            end
            else
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // sticky flags: a new event wins over a read or a clear in the same cycle
    always_comb
    begin
        flags_set.underflow_flag = underflow;
        flags_set.window_error_flag = restart_err;
        flags_d = flags_q;
        if (flags_rd)
        begin
            flags_d = flags_t'(FLAGS_RESET);
        end
        if (irq_clr_wr)
        begin
            flags_d = flags_t'(flags_d & ~WDATA_I[FLAG_W-1:0]);
        end
        flags_d = flags_t'(flags_d | flags_set);
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            flags_q <= flags_t'(FLAGS_RESET);
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    // fault request held until the status read or the reset it causes
    always_comb
    begin
        fault_d = fault_q && !flags_rd;
        if ((underflow || restart_err) && mode_q.fault_reset_enable)
        begin
            fault_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            fault_q <= 1'b0;
        end
        else
        begin
            fault_q <= fault_d;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            irq_en_q <= IRQ_EN_RESET;
        end
        else if (WR_I && hit(ADDR_I, OFF_IRQ_ENABLE))
        begin
            irq_en_q <= WDATA_I[FLAG_W-1:0];
        end
    end

    // read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            rdata_q <= '0;
        end
        else if (RD_I)
        begin
            if (hit(ADDR_I, OFF_MODE))
            begin
                rdata_q <= 32'(mode_q);
            end
            else if (flags_rd)
            begin
                rdata_q <= {30'h0, flags_q};
            end
            else if (hit(ADDR_I, OFF_IRQ_ENABLE))
            begin
                rdata_q <= {30'h0, irq_en_q};
            end
            else
            begin
                rdata_q <= '0;
            end
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    assign RDATA_O = rdata_q;
    assign IRQ_O = mode_q.fault_interrupt_enable && |(flags_q & irq_en_q);
    assign FAULT_O = fault_q;
    assign PROC_RESET_REQ_O = fault_q && mode_q.processor_only_reset_select;
    assign FULL_RESET_REQ_O = fault_q && !mode_q.processor_only_reset_select;

    // checks
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    sequence s_good_restart;
        restart_wr && key_ok && WDATA_I[RESTART_BIT]
            && (cnt_q <= mode_q.restart_window_delta) && !mode_wr_ok;
    endsequence

    sequence s_late_restart;
        restart_wr && key_ok && WDATA_I[RESTART_BIT]
            && (cnt_q > mode_q.restart_window_delta);
    endsequence

    sequence s_bad_key;
        WR_I && hit(ADDR_I, OFF_RESTART) && !key_ok && !RD_I;
    endsequence

    a_reset_defaults: assert property (@(posedge CLK_I) disable iff (1'b0)
        $past(RST_I) |-> (32'(mode_q) == MODE_RESET) && (cnt_q == CNT_MAX) && !FAULT_O)
        else $error("reset state of mode or counter wrong");

    a_mode_write_once: assert property (
        mode_locked_q && WR_I && hit(ADDR_I, OFF_MODE) |=> $stable(mode_q))
        else $error("locked mode register changed");

    a_mode_reload: assert property (
        mode_wr_ok |=> (cnt_q == $past(WDATA_I[CNT_W-1:0])) && (presc_q == PRESC_ZERO))
        else $error("mode write did not reload counter");

    a_restart_reload: assert property (
        s_good_restart |=> (cnt_q == mode_q.counter_load_value) && (presc_q == PRESC_ZERO))
        else $error("restart did not reload counter and prescaler");

    a_key_guard: assert property (
        s_bad_key |=> $stable(flags_q.window_error_flag) && (presc_q != PRESC_ZERO
            || $past(presc_q) == PRESC_LAST || $past(presc_q) == PRESC_ZERO))
        else $error("restart write with wrong key had an effect");

    a_window_error: assert property (
        s_late_restart |=> flags_q.window_error_flag
            && (FAULT_O == $past(mode_q.fault_reset_enable || fault_q)))
        else $error("late restart not flagged");

    a_underflow_flag: assert property (
        underflow |=> flags_q.underflow_flag && (FAULT_O || !mode_q.fault_reset_enable))
        else $error("underflow not flagged");

    a_irq_gate: assert property (
        !mode_q.fault_interrupt_enable |-> !IRQ_O)
        else $error("interrupt without fault interrupt enable");

    a_read_clears: assert property (
        flags_rd && !underflow && !restart_err |=> (flags_q == flags_t'(FLAGS_RESET)) && !FAULT_O)
        else $error("status read did not clear flags and fault");

    a_halt_hold: assert property (
        halted && !mode_wr_ok && !restart_ok |=> $stable(cnt_q)
            && !$rose(flags_q.underflow_flag))
        else $error("halted counter moved");

    a_reset_select: assert property (
        FAULT_O |-> (PROC_RESET_REQ_O != FULL_RESET_REQ_O)
            && (PROC_RESET_REQ_O == mode_q.processor_only_reset_select))
        else $error("reset request select wrong");

    a_tick_spacing: assert property (
        tick |=> !tick [*8])
        else $error("prescaler ticks too close");

    a_count_bound: assert property (
        cnt_q <= mode_q.counter_load_value)
        else $error("counter above its load value");

    a_reset_clears: assert property (@(posedge CLK_I) disable iff (1'b0)
        $past(RST_I) |-> (flags_q == flags_t'(FLAGS_RESET)) && !IRQ_O)
        else $error("reset left flags or interrupt set");
endmodule
`default_nettype wire

/* File: inc/wdt_pkg.sv */
// windowed watchdog: register map, mode field layout, reset values, timing
// assumes a 32-bit register port with byte addresses and one core clock
`default_nettype none
package wdt_pkg;
    localparam int CNT_W = 12;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_RESTART = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h10;

    // restart_command layout
    localparam int KEY_LSB = 24;
    localparam logic [7:0] RESTART_KEY = 8'hA5;
    localparam int RESTART_BIT = 0;

    // once_mode_setup layout, bits 31:30 read as zero
    typedef struct packed {
        logic [1:0] reserved;
        logic idle_halt_select;
        logic debug_halt_select;
        logic [CNT_W-1:0] restart_window_delta;
        logic timer_disable;
        logic processor_only_reset_select;
        logic fault_reset_enable;
        logic fault_interrupt_enable;
        logic [CNT_W-1:0] counter_load_value;
    } mode_t;

    localparam logic [31:0] MODE_RESET = 32'h3FFF_2FFF;
    localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;

    // fault_flags layout: bit 0 underflow, bit 1 window error
    typedef struct packed {
        logic window_error_flag;
        logic underflow_flag;
    } flags_t;

    localparam int FLAG_W = 2;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 2'h0;
    localparam logic [FLAG_W-1:0] IRQ_EN_RESET = 2'h3;

    // slow clock prescaler
    localparam int SLOW_DIV = 128;
endpackage
`default_nettype wire

/* File: verification/fault_reset_model.sv */
// reset controller model: answers a fault request with a reset pulse
// assumes one clock shared with the watchdog; dly_i sets how slowly it answers
`timescale 1ns/1ps
`default_nettype none
module fault_reset_model (
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic [7:0] dly_i,
    input wire logic fault_i,
    output logic rst_o = 1'b0
);
    logic [7:0] cnt_q = 8'h00;
    logic busy_q = 1'b0;

    // three-cycle pulse, long enough for a synchronous reset to land
    always @(posedge clk_i)
    begin
        if (busy_q)
        begin
            cnt_q <= cnt_q + 8'h01;
            rst_o <= (cnt_q >= dly_i);
            busy_q <= (cnt_q < dly_i + 8'h02);
        end
        else
        begin
            rst_o <= 1'b0;
            if (en_i && fault_i)
            begin
                busy_q <= 1'b1;
                cnt_q <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/test_windowed_watchdog_timer.sv */
// self-checking bench: register port traffic, halts, faults, reset answers
// assumes prescaler shrunk to 4 and a 40 ns slow clock, so ticks are quick
`timescale 1ns/1ps
`default_nettype none
module test_windowed_watchdog_timer
    import wdt_pkg::*;
();
    logic clk, slck, tb_rst, model_rst, rst, wr, rd, dbg, idle;
    logic irq, fault, proc_req, full_req, m_en;
    logic pend = 1'b0;
    logic [7:0] m_dly, k;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata, m1, m2, m3;
    logic [31:0] exp_q[$];
    int error_cnt, checks, n;

    assign rst = tb_rst | model_rst;

    windowed_watchdog_timer #(.PRESC_DIV(4)) DUT (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SLCK_I(slck), .DBG_I(dbg),
        .IDLE_I(idle), .IRQ_O(irq), .FAULT_O(fault), .PROC_RESET_REQ_O(proc_req),
        .FULL_RESET_REQ_O(full_req));

    fault_reset_model partner (.clk_i(clk), .en_i(m_en), .dly_i(m_dly), .fault_i(fault),
        .rst_o(model_rst));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        slck = 1'b0;
        forever #20 slck = ~slck;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // expected read data is queued; the monitor pairs it with the answer
    task automatic rd32(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic outs(input logic [3:0] e);
        chk({28'h0, irq, fault, proc_req, full_req}, {28'h0, e});
    endtask

    task automatic wait_fault;
        n = 0;
        while (fault !== 1'b1 && n < 1000)
        begin
            @(posedge clk);
            n++;
        end
        #1;
        chk({31'h0, fault}, 32'h1);
    endtask

    // answer stands only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (pend)
            chk(rdata, exp_q.pop_front());
        pend = rd;
    end

    initial
    begin
        #200000;
        error_cnt++;
        summarize();
    end

    initial
    begin
        tb_rst = 1'b1;
        {wr, rd, dbg, idle, m_en} = 5'h00;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        m_dly = 8'h0a;
        error_cnt = 0;
        checks = 0;
        void'($urandom(32'h20dd));
        k = 8'($urandom_range(254));
        if (k >= RESTART_KEY)
            k = k + 8'h01;
        m1 = {4'h3, 12'h002, 4'h7, 12'h008};
        m2 = {4'h0, 12'h000, 4'h9, 12'h001};
        m3 = {4'h0, 12'h000, 4'h2, 12'h001};
        repeat (5) @(posedge clk);
        tb_rst <= 1'b0;
        rd32(OFF_MODE, MODE_RESET);
        rd32(OFF_FLAGS, 32'h0000_0000);
        rd32(8'h20, 32'h0000_0000);
        wr32(OFF_RESTART, {RESTART_KEY, 24'h00_0001});
        step(2);
        outs(4'h0);
        wr32(OFF_MODE, m1);
        wr32(OFF_MODE, $urandom());
        rd32(OFF_MODE, m1);
        wr32(OFF_RESTART, {k, 24'h00_0001});
        step(2);
        outs(4'h0);
        wr32(OFF_RESTART, {RESTART_KEY, 24'h00_0001});
        step(1);
        outs(4'he);
        rd32(OFF_FLAGS, 32'h0000_0002);
        step(1);
        outs(4'h0);
        for (int h = 0; h < 2; h++)
        begin
            dbg <= (h == 0);
            idle <= (h == 1);
            step(300);
            outs(4'h0);
        end
        dbg <= 1'b0;
        idle <= 1'b0;
        wait_fault();
        outs(4'he);
        wr32(OFF_IRQ_ENABLE, 32'h0000_0000);
        step(1);
        outs(4'h6);
        wr32(OFF_IRQ_ENABLE, 32'h0000_0003);
        rd32(OFF_FLAGS, 32'h0000_0001);
        step(1);
        outs(4'h0);
        wait_fault();
        wr32(OFF_IRQ_CLEAR, 32'h0000_0001);
        step(1);
        chk({31'h0, irq}, 32'h0);
        rd32(OFF_FLAGS, 32'h0000_0000);
        m_en <= 1'b1;
        wr32(OFF_RESTART, {RESTART_KEY, 24'h00_0001});
        step(1);
        outs(4'he);
        step(20);
        rd32(OFF_MODE, MODE_RESET);
        rd32(OFF_FLAGS, 32'h0000_0000);
        wr32(OFF_MODE, m2);
        step(300);
        outs(4'h0);
        m_dly <= 8'h01;
        // reset generation is off in m2: the late restart only flags and interrupts
        wr32(OFF_RESTART, {RESTART_KEY, 24'h00_0001});
        step(1);
        outs(4'h8);
        tb_rst <= 1'b1;
        step(2);
        tb_rst <= 1'b0;
        rd32(OFF_FLAGS, 32'h0000_0000);
        wr32(OFF_MODE, m3);
        wr32(OFF_RESTART, {RESTART_KEY, 24'h00_0001});
        step(1);
        outs(4'h5);
        step(10);
        rd32(OFF_MODE, MODE_RESET);
        step(3);
        summarize();
    end
endmodule
`default_nettype wire
